//--- design/spc_top.sv
// stepper pulse controller: ahb-lite registers, three trapezoidal pulse engines
// Operation
// - three channels, each own pulse and direction
// - rate accepted only within 1 to 10000
// - with nonzero ramp, start and end at eighth of maximum
// - ramp steps accelerate and decelerate equally
// - direction high while moving negative
// - relative move emits magnitude of signed count
// - half-step flag only stored and shown in status
// - completion flag set after last pulse
// - accepted move clears its completion flag
// - settings kept until rewritten, lost on reset
// - soft reset keeps rate and ramp settings
// - selector 1 to 3 picks controller channel
// - general outputs taken over as dir, pulse
// - absolute move derives count, direction from difference
// - position signed 32 bits from home
// - moves ignored while channel busy
`timescale 1ns/1ns
module spc_top
  import spc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // driver pins
  output logic [NCH-1:0] step_pulse,
  output logic [NCH-1:0] step_dir,
  output logic [NOUT-1:0] gen_out
);
  // *****************************************************************
  // helpers
  // *****************************************************************
  // channel window of the register map
  function automatic logic chan_hit(input logic [7:0] a);
    return (a >= OFF_CH0) && (a < OFF_CH0 + 8'(NCH) * CH_STRIDE);
  endfunction : chan_hit

  function automatic logic [1:0] chan_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_CH0;
    return d[5:4];
  endfunction : chan_idx

  // starting rate, never below one pulse per second
  function automatic logic [RATE_W-1:0] base_rate(input logic [RATE_W-1:0] r);
    return ((r >> 3) == '0) ? RATE_LO : (r >> 3);
  endfunction : base_rate

  // *****************************************************************
  // bus slave
  // *****************************************************************
  logic take;
  logic wr_r;
  logic rd_r;
  logic [7:0] addr_r;
  logic [31:0] rdata_r;
  logic [31:0] arg_r;
  logic [31:0] gpo_r;
  logic [NFLAG-1:0] flag_r;
  spc_cmd_t cmd;
  logic cmd_go;
  logic [1:0] cmd_ch;
  logic [NCH-1:0] move_ok;

  assign take = hsel && htrans[1] && hready;
  assign hreadyout = !rd_r;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign cmd = spc_cmd_t'(hwdata);
  assign cmd_go = wr_r && (addr_r == OFF_CMD) && (cmd.sel != 2'd0);
  assign cmd_ch = cmd.sel - 2'd1;

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_r <= take && hwrite;
      rd_r <= take && !hwrite;
      if (take) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // plain software registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arg_r <= 32'h0000_0000;
      gpo_r <= GPO_RST;
    end else if (wr_r) begin
      if (addr_r == OFF_ARG) begin
        arg_r <= hwdata;
      end
      if (addr_r == OFF_GPO) begin
        gpo_r <= hwdata;
      end
    end
  end

  // *****************************************************************
  // rate profiles
  // *****************************************************************
  spc_prof_t prof_r [NCH];

  // only a power-on reset wipes these; the soft reset command leaves them
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (srst) begin
        prof_r[c] <= '0;
      end else if (wr_r && chan_hit(addr_r) && chan_idx(addr_r) == 2'(c)) begin
        if (addr_r[3:0] == SUB_RATE && hwdata >= 32'(RATE_LO)
            && hwdata <= 32'(RATE_HI)) begin
          prof_r[c].rate <= hwdata[RATE_W-1:0];
          prof_r[c].valid <= 1'b1;
        end
        if (addr_r[3:0] == SUB_RAMP) begin
          prof_r[c].ramp <= hwdata;
        end
      end
    end
  end

  // *****************************************************************
  // pulse engines
  // *****************************************************************
  spc_state_t st_r [NCH];
  logic [31:0] rem_r [NCH];
  logic [31:0] pos_r [NCH];
  logic [31:0] emit_r [NCH];
  logic [31:0] up_r [NCH];
  logic signed [33:0] err_r [NCH];
  logic [RATE_W-1:0] rate_r [NCH];
  logic [28:0] ph_r [NCH];
  logic [10:0] pw_r [NCH];
  logic [2:0] fidx_r [NCH];
  logic [NCH-1:0] pulse_r;
  logic [NCH-1:0] dir_r;
  logic [NCH-1:0] mode_r;
  logic [NCH-1:0] half_r;
  logic [NCH-1:0] abort_r;
  logic [NCH-1:0] done_r;
  logic soft_go;

  assign soft_go = wr_r && (addr_r == OFF_CMD) && (cmd.op == OP_SOFT);

  // a move is taken only on an idle, loaded channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      move_ok[c] = cmd_go && cmd_ch == 2'(c) && (cmd.op == OP_REL || cmd.op == OP_ABS)
                   && st_r[c] == ST_IDLE
                   && prof_r[c].valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NCH; c++) begin
      logic signed [32:0] dlt;
      logic [28:0] ph_n;
      logic [RATE_W-1:0] diff;
      dlt = (cmd.op == OP_ABS) ? $signed({arg_r[31], arg_r}) - $signed({pos_r[c][31], pos_r[c]})
                               : $signed({arg_r[31], arg_r});
      ph_n = ph_r[c] + 29'(rate_r[c]);
      diff = prof_r[c].rate - base_rate(prof_r[c].rate);
      if (srst) begin
        st_r[c] <= ST_IDLE;
        rem_r[c] <= 32'h0000_0000;
        pos_r[c] <= 32'h0000_0000;
        emit_r[c] <= 32'h0000_0000;
        up_r[c] <= 32'h0000_0000;
        err_r[c] <= '0;
        rate_r[c] <= RATE_LO;
        ph_r[c] <= 29'h0000_0000;
        pw_r[c] <= 11'h000;
        fidx_r[c] <= 3'h0;
        pulse_r[c] <= 1'b0;
        dir_r[c] <= 1'b0;
        mode_r[c] <= 1'b0;
        half_r[c] <= 1'b0;
        abort_r[c] <= 1'b0;
        done_r[c] <= 1'b0;
      end else if (soft_go) begin
        // motion stops at once; settings and position survive
        st_r[c] <= ST_IDLE;
        rem_r[c] <= 32'h0000_0000;
        pw_r[c] <= 11'h000;
        pulse_r[c] <= 1'b0;
        mode_r[c] <= 1'b0;
        done_r[c] <= 1'b0;
      end else begin
        done_r[c] <= 1'b0;
        if (move_ok[c]) begin
          st_r[c] <= ST_RUN;
          dir_r[c] <= dlt[32];
          rem_r[c] <= dlt[32] ? 32'(-dlt) : dlt[31:0];
          emit_r[c] <= 32'h0000_0000;
          up_r[c] <= 32'h0000_0000;
          err_r[c] <= '0;
          rate_r[c] <= (prof_r[c].ramp == '0) ? prof_r[c].rate
                                              : base_rate(prof_r[c].rate);
          ph_r[c] <= 29'h0000_0000;
          fidx_r[c] <= cmd.flag;
          mode_r[c] <= 1'b1;
          half_r[c] <= cmd.half;
          abort_r[c] <= 1'b0;
        end else if (st_r[c] == ST_IDLE) begin
          if (cmd_go && cmd_ch == 2'(c) && cmd.op == OP_HOME) begin
            pos_r[c] <= 32'h0000_0000;
          end
        end else begin
          if (cmd_go && cmd_ch == 2'(c) && cmd.op == OP_STOP) begin
            rem_r[c] <= 32'h0000_0000;
            abort_r[c] <= 1'b1;
          end
          // pulse width timer
          if (pw_r[c] != 11'h000) begin
            pw_r[c] <= pw_r[c] - 11'h001;
            if (pw_r[c] == 11'h001) begin
              pulse_r[c] <= 1'b0;
            end
          end
          if (rem_r[c] != '0 && !(cmd_go && cmd_ch == 2'(c) && cmd.op == OP_STOP)) begin
            if (ph_n >= CLK_HZ) begin
              // one step: pulse, count, position, then profile
              ph_r[c] <= ph_n - CLK_HZ;
              pulse_r[c] <= 1'b1;
              pw_r[c] <= PULSE_LEN;
              rem_r[c] <= rem_r[c] - 32'h1;
              emit_r[c] <= emit_r[c] + 32'h1;
              pos_r[c] <= dir_r[c] ? pos_r[c] - 32'h1 : pos_r[c] + 32'h1;
              if (rem_r[c] - 32'h1 <= up_r[c] && up_r[c] != '0) begin
                up_r[c] <= up_r[c] - 32'h1;
                err_r[c] <= err_r[c] - 34'(diff);
              end else if (up_r[c] < prof_r[c].ramp) begin
                up_r[c] <= up_r[c] + 32'h1;
                err_r[c] <= err_r[c] + 34'(diff);
              end
            end else begin
              ph_r[c] <= ph_n;
              // step the rate up or down toward the ramp line one unit a cycle
              if (prof_r[c].ramp != '0 && err_r[c] >= $signed({2'b00, prof_r[c].ramp})) begin
                rate_r[c] <= rate_r[c] + 14'h0001;
                err_r[c] <= err_r[c] - $signed({2'b00, prof_r[c].ramp});
              end else if (err_r[c] < 0) begin
                rate_r[c] <= rate_r[c] - 14'h0001;
                err_r[c] <= err_r[c] + $signed({2'b00, prof_r[c].ramp});
              end
            end
          end else if (pw_r[c] == 11'h000) begin
            // finish only once the last pulse is low again
            st_r[c] <= ST_IDLE;
            // a stop landing on this very cycle must not raise the flag either
            done_r[c] <= !abort_r[c]
                         && !(cmd_go && cmd_ch == 2'(c) && cmd.op == OP_STOP);
          end
        end
      end
    end
  end

  // *****************************************************************
  // completion flags
  // *****************************************************************
  // completion beats both clears arriving in the same cycle
  always_ff @(posedge sys_clk) begin
    for (int f = 0; f < NFLAG; f++) begin
      logic set;
      logic clr;
      set = 1'b0;
      clr = wr_r && addr_r == OFF_FLAG && hwdata[f];
      for (int c = 0; c < NCH; c++) begin
        if (done_r[c] && fidx_r[c] == 3'(f)) begin
          set = 1'b1;
        end
        if (move_ok[c] && cmd.flag == 3'(f)) begin
          clr = 1'b1;
        end
      end
      if (srst) begin
        flag_r[f] <= 1'b0;
      end else if (set) begin
        flag_r[f] <= 1'b1;
      end else if (clr) begin
        flag_r[f] <= 1'b0;
      end
    end
  end

  // *****************************************************************
  // output pins
  // *****************************************************************
  assign step_pulse = pulse_r;
  assign step_dir = dir_r;

  // controller channels take over their general outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gen_out <= NOUT'(GPO_RST);
    end else begin
      for (int o = 0; o < NOUT; o++) begin
        gen_out[o] <= gpo_r[o];
      end
      for (int c = 0; c < NCH; c++) begin
        if (mode_r[c]) begin
          gen_out[c] <= dir_r[c];
          gen_out[PULSE_BASE + c] <= pulse_r[c];
        end
      end
    end
  end

  // *****************************************************************
  // read data
  // *****************************************************************
  // unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    logic [1:0] ci;
    ci = chan_idx(addr_r);
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_r) begin
      rdata_r <= 32'h0000_0000;
      if (addr_r == OFF_ARG) begin
        rdata_r <= arg_r;
      end else if (addr_r == OFF_FLAG) begin
        rdata_r <= 32'(flag_r);
      end else if (addr_r == OFF_STAT) begin
        for (int c = 0; c < NCH; c++) begin
          rdata_r[STAT_BUSY + c] <= st_r[c] == ST_RUN;
          rdata_r[STAT_MODE + c] <= mode_r[c];
          rdata_r[STAT_HALF + c] <= half_r[c];
        end
      end else if (addr_r == OFF_GPO) begin
        rdata_r <= gpo_r;
      end else if (chan_hit(addr_r)) begin
        unique case (addr_r[3:0])
          SUB_RATE: rdata_r <= 32'(prof_r[ci].rate);
          SUB_RAMP: rdata_r <= prof_r[ci].ramp;
          SUB_POS: rdata_r <= pos_r[ci];
          SUB_CNT: rdata_r <= emit_r[ci];
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : spc_top

//--- inc/spc_pkg.sv
// constants and carrier types of the three-channel stepper pulse controller
package spc_pkg;
  // *****************************************************************
  // geometry
  // *****************************************************************
  localparam int NCH = 3;
  localparam int NFLAG = 8;
  localparam int NOUT = 8;
  localparam int PULSE_BASE = 4; // general output index of channel 0 pulse
  // *****************************************************************
  // register map (byte addresses)
  // *****************************************************************
  localparam logic [7:0] OFF_ARG = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_GPO = 8'h10;
  localparam logic [7:0] OFF_CH0 = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] SUB_RATE = 4'h0;
  localparam logic [3:0] SUB_RAMP = 4'h4;
  localparam logic [3:0] SUB_POS = 4'h8;
  localparam logic [3:0] SUB_CNT = 4'hC;
  localparam int STAT_BUSY = 0;
  localparam int STAT_MODE = 4;
  localparam int STAT_HALF = 8;
  // *****************************************************************
  // rate and timing
  // *****************************************************************
  localparam int RATE_W = 14;
  localparam logic [13:0] RATE_LO = 14'h0001;
  localparam logic [13:0] RATE_HI = 14'h2710;
  localparam int CLK_MHZ = 250;
  localparam logic [28:0] CLK_HZ = 29'h0EE6B280;
  localparam int PULSE_NS = 5000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [10:0] PULSE_LEN = 11'(PULSE_CYC);
  localparam logic [31:0] GPO_RST = 32'h0000_0000;
  // *****************************************************************
  // types
  // *****************************************************************
  typedef enum logic [2:0] {OP_NONE, OP_REL, OP_ABS, OP_STOP, OP_HOME, OP_SOFT} spc_op_t;
  typedef struct packed {
    logic [22:0] rsvd;
    logic half;
    logic [2:0] flag;
    spc_op_t op;
    logic [1:0] sel;
  } spc_cmd_t;
  typedef struct packed {
    logic valid;
    logic [RATE_W-1:0] rate;
    logic [31:0] ramp;
  } spc_prof_t;
  typedef enum logic {ST_IDLE, ST_RUN} spc_state_t;
endpackage : spc_pkg

//--- tb/spc_checker.sv
// concurrent checks on the stepper pulse controller ports
`timescale 1ns/1ns
module spc_checker
  import spc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // driver pins
  input wire logic [NCH-1:0] step_pulse,
  input wire logic [NCH-1:0] step_dir,
  input wire logic [NOUT-1:0] gen_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [10:0] hi_r;
  logic [15:0] gap_r;
  logic req;
  assign req = hsel & htrans[1] & hready;
  // high-time and rise-to-rise counters of channel 0; gap saturates so the first pulse passes
  always_ff @(posedge sys_clk) begin
    if (srst) hi_r <= 11'h000;
    else hi_r <= step_pulse[0] ? hi_r + 11'h001 : 11'h000;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) gap_r <= 16'hFFFF;
    else if (step_pulse[0] && !hi_r[0] && hi_r == 11'h000) gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end
  property p_dir_setup;
    (step_pulse & ~$past(step_pulse) & (step_dir ^ $past(step_dir))) == 3'h0;
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("dir moved at pulse start");
  property p_dir_hold;
    (step_pulse & $past(step_pulse) & (step_dir ^ $past(step_dir))) == 3'h0;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir moved during pulse");
  property p_gen_pulse;
    ($past(step_pulse) & ~gen_out[6:4]) == 3'h0;
  endproperty
  a_gen_pulse: assert property (p_gen_pulse) else $error("pulse not on general out");
  property p_pulse_width;
    $fell(step_pulse[0]) |-> $past(hi_r) == PULSE_LEN - 11'h001 || hi_r == PULSE_LEN;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_rate_max;
    $rose(step_pulse[0]) |-> gap_r >= 16'h61A7; // one period at the top rate, less one
  endproperty
  a_rate_max: assert property (p_rate_max) else $error("pulses too close");
  property p_read_wait;
    req && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_nowait;
    req && hwrite |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_reset_quiet;
    $past(srst) |-> step_pulse == 3'h0 && step_dir == 3'h0 && gen_out == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live after reset");
  c_pulse: cover property ($rose(step_pulse[0]));
  c_neg: cover property ($rose(step_dir[0]));
  c_read: cover property (req && !hwrite);
endmodule : spc_checker

//--- tb/spc_drv_model.sv
// external pulse/direction driver: counts pulses and tracks shaft position
`timescale 1ns/1ns
module spc_drv_model
  import spc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [NCH-1:0] step_pulse,
  input wire logic [NCH-1:0] step_dir
);
  int pulses [NCH];
  int pos [NCH];
  logic [NCH-1:0] prev = '0;
  // one count per rising edge; dir high steps backwards
  always @(posedge sys_clk) begin
    prev <= step_pulse;
    for (int c = 0; c < NCH; c++) begin
      if (step_pulse[c] && !prev[c]) begin
        pulses[c] <= pulses[c] + 1;
        pos[c] <= pos[c] + (step_dir[c] ? -1 : 1);
      end
    end
  end
endmodule : spc_drv_model

//--- tb/tb.sv
// testbench of the stepper pulse controller over ahb-lite
`timescale 1ns/1ns
module tb;
  import spc_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata, q;
  logic [NCH-1:0] step_pulse, step_dir;
  logic [NOUT-1:0] gen_out;
  int fails = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  always #2 sys_clk = ~sys_clk;
  spc_top dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .step_pulse(step_pulse), .step_dir(step_dir),
    .gen_out(gen_out));
  spc_drv_model drv (.sys_clk(sys_clk), .step_pulse(step_pulse), .step_dir(step_dir));
  task print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // ready is judged mid-cycle where it is settled, signals move only after the edge
  task wait_rdy;
    forever begin
      @(negedge sys_clk);
      if (hreadyout === 1'b1) break;
    end
    q = hrdata;
    @(posedge sys_clk);
  endtask : wait_rdy
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : xfer
  function automatic logic [7:0] ca(input int c, input logic [3:0] s);
    return OFF_CH0 + 8'(c) * CH_STRIDE + {4'h0, s};
  endfunction : ca
  task move(input logic [2:0] op, input logic [31:0] arg, input logic [2:0] f,
      input logic h, input logic [1:0] sel);
    spc_cmd_t k;
    k = '0;
    k.sel = sel;
    k.op = spc_op_t'(op);
    k.flag = f;
    k.half = h;
    xfer(1'b1, OFF_ARG, arg);
    xfer(1'b1, OFF_CMD, 32'(k));
  endtask : move
  // poll busy with a bounded count; a move at full rate is a few ten thousand cycles
  task wait_idle;
    for (int i = 0; i < 1000; i++) begin
      xfer(1'b0, OFF_STAT, 32'h0);
      if (q[STAT_BUSY] === 1'b0) break;
      repeat (100) @(posedge sys_clk);
    end
    check("idle", 32'(q[STAT_BUSY]), 32'h0);
  endtask : wait_idle
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, ca(0, SUB_RATE), 32'h0);
    check("rate reset", q, 32'h0);
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("flags reset", q, 32'h0);
    // out-of-range rates are dropped, the top bound is kept
    xfer(1'b1, ca(0, SUB_RATE), 32'h0);
    xfer(1'b1, ca(0, SUB_RATE), {18'h0, RATE_HI + 14'h0001});
    xfer(1'b0, ca(0, SUB_RATE), 32'h0);
    check("rate refused", q, 32'h0);
    xfer(1'b1, ca(0, SUB_RATE), {18'h0, RATE_HI});
    xfer(1'b1, ca(0, SUB_RAMP), 32'h0);
    xfer(1'b0, ca(0, SUB_RATE), 32'h0);
    check("rate max", q, {18'h0, RATE_HI});
    // channel 1 has no profile yet, so its move must not start
    move(3'h1, 32'h1, 3'h2, 1'b0, 2'h2);
    xfer(1'b0, OFF_STAT, 32'h0);
    check("no profile", 32'(q[1]), 32'h0);
    move(3'h1, 32'h2, 3'h1, 1'b0, 2'h1);
    xfer(1'b0, OFF_STAT, 32'h0);
    check("busy mode", 32'({q[STAT_MODE], q[STAT_BUSY]}), 32'h3);
    check("dir fwd", 32'(step_dir[0]), 32'h0);
    move(3'h1, 32'h5, 3'h1, 1'b0, 2'h1);
    wait_idle();
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("flag set", 32'(q[1]), 32'h1);
    xfer(1'b0, ca(0, SUB_POS), 32'h0);
    check("pos rel", q, 32'h2);
    xfer(1'b0, ca(0, SUB_CNT), 32'h0);
    check("emitted", q, 32'h2);
    check("pulses", 32'(drv.pulses[0]), 32'h2);
    move(3'h5, 32'h0, 3'h0, 1'b0, 2'h1);
    xfer(1'b0, ca(0, SUB_RATE), 32'h0);
    check("rate kept", q, {18'h0, RATE_HI});
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("flag kept", 32'(q[1]), 32'h1);
    // absolute target below the position: one backward step, half flag set
    move(3'h2, 32'h1, 3'h1, 1'b1, 2'h1);
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("flag clr", 32'(q[1]), 32'h0);
    xfer(1'b0, OFF_STAT, 32'h0);
    check("half", 32'(q[STAT_HALF]), 32'h1);
    repeat (10) @(posedge sys_clk);
    check("dir back", 32'(step_dir[0]), 32'h1);
    check("gen dir", 32'(gen_out[0]), 32'h1);
    wait_idle();
    xfer(1'b0, ca(0, SUB_POS), 32'h0);
    check("pos abs", q, 32'h1);
    check("drv pos", 32'(drv.pos[0]), 32'h1);
    move(3'h4, 32'h0, 3'h0, 1'b0, 2'h1);
    xfer(1'b0, ca(0, SUB_POS), 32'h0);
    check("home", q, 32'h0);
    // a stop before the first step ends the move with no pulse and no flag
    move(3'h1, 32'h2, 3'h4, 1'b0, 2'h1);
    move(3'h3, 32'h0, 3'h0, 1'b0, 2'h1);
    wait_idle();
    xfer(1'b0, ca(0, SUB_CNT), 32'h0);
    check("stop count", q, 32'h0);
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("stop flag", 32'(q[4]), 32'h0);
    move(3'h2, 32'h0, 3'h3, 1'b0, 2'h1);
    repeat (4) @(posedge sys_clk);
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("zero move", 32'(q[3]), 32'h1);
    xfer(1'b1, OFF_GPO, 32'h8);
    repeat (2) @(posedge sys_clk);
    check("gpo", 32'(gen_out[3]), 32'h1);
    xfer(1'b0, 8'h80, 32'h0);
    check("unmapped", q, 32'h0);
    // the third channel answers its own selector
    xfer(1'b1, ca(2, SUB_RATE), {18'h0, RATE_LO});
    xfer(1'b0, ca(2, SUB_RATE), 32'h0);
    check("rate min", q, {18'h0, RATE_LO});
    move(3'h1, 32'h0, 3'h5, 1'b0, 2'h3);
    repeat (4) @(posedge sys_clk);
    xfer(1'b0, OFF_FLAG, 32'h0);
    check("ch2 flag", 32'(q[5]), 32'h1);
    xfer(1'b0, OFF_STAT, 32'h0);
    check("ch2 mode", 32'(q[STAT_MODE + 2]), 32'h1);
    // a mid-run reset wipes the profiles and the general outputs
    srst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check("gen reset", 32'(gen_out), 32'h0);
    xfer(1'b0, ca(0, SUB_RATE), 32'h0);
    check("rate lost", q, 32'h0);
    print_verdict();
  end
endmodule : tb
bind spc_top spc_checker chk (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .step_pulse(step_pulse), .step_dir(step_dir), .gen_out(gen_out));
